// file: srxpc_pkg.sv
/*
  srxpc_pkg: register map, field positions, reset values and the serial
  port framing constants shared by the receive PHY control register bank.
  Assumes a byte-wide register space addressed by a 15-bit serial address.
*/
package srxpc_pkg;

  localparam int unsigned ADDR_W = 15;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned LANES  = 8;

  // serial framing: one direction bit, address, then data bytes
  localparam int unsigned INSTR_BITS = 16;
  localparam logic [4:0]  INSTR_LAST = 5'h0F;

  localparam logic [ADDR_W-1:0] ADDR_MASTER_PD = 15'h0200;
  localparam logic [ADDR_W-1:0] ADDR_PHY_PD    = 15'h0201;
  localparam logic [ADDR_W-1:0] ADDR_GEN_PD    = 15'h0203;
  localparam logic [ADDR_W-1:0] ADDR_CDR_RST   = 15'h0206;
  localparam logic [ADDR_W-1:0] ADDR_CDR_MODE  = 15'h0230;
  localparam logic [ADDR_W-1:0] ADDR_EQ_01     = 15'h0250;

  localparam logic [DATA_W-1:0] RST_MASTER_PD = 8'h01;
  localparam logic [DATA_W-1:0] RST_PHY_PD    = 8'h00;
  localparam logic [DATA_W-1:0] RST_GEN_PD    = 8'h00;
  localparam logic [DATA_W-1:0] RST_CDR_RST   = 8'h01;
  localparam logic [DATA_W-1:0] RST_CDR_MODE  = 8'h20;
  localparam logic [DATA_W-1:0] RST_EQ_01     = 8'h88;

  localparam int unsigned MASTER_PD_BIT = 0;
  localparam int unsigned SYNC_PD_BIT   = 1;
  localparam int unsigned GEN_RSV_BIT   = 0;
  localparam int unsigned CDR_RUN_BIT   = 0;
  localparam int unsigned HALF_RATE_BIT = 5;
  localparam int unsigned DIV_LSB       = 1;
  localparam int unsigned DIV_W         = 2;
  localparam int unsigned EQ0_LSB       = 0;
  localparam int unsigned EQ1_LSB       = 4;
  localparam int unsigned EQ_W          = 4;

  localparam logic [DIV_W-1:0] DIV_NONE = 2'h0;
  localparam logic [DIV_W-1:0] DIV_BY2  = 2'h1;
  localparam logic [DIV_W-1:0] DIV_BY4  = 2'h2;
  localparam logic [EQ_W-1:0]  EQ_MANUAL = 4'h0;

endpackage : srxpc_pkg

// file: srxpc_serial_port.sv
/*
  srxpc_serial_port: four-wire serial control port slave. Frames are a
  16-bit instruction (direction bit, 15-bit address, MSB first) followed by
  data bytes with the address rising by one per byte.
  Assumes chip select, serial clock and data in are synchronous to core_clk_i
  and the serial clock runs at most at one quarter of the core clock.
*/
`timescale 1ns/10ps
module srxpc_serial_port #(
  parameter int unsigned AW = 15,
  parameter int unsigned DW = 8
) (
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          cs_n_i,
  input  wire logic          sclk_i,
  input  wire logic          sdi_i,
  input  wire logic [DW-1:0] rd_data_i,
  output logic               sdo_o,
  output logic               sdo_oe_n_o,
  output logic [AW-1:0]      addr_o,
  output logic               wr_stb_o,
  output logic [AW-1:0]      wr_addr_o,
  output logic [DW-1:0]      wr_data_o
);

  logic          sclk_q;
  logic [4:0]    icnt_q;
  logic [2:0]    dcnt_q;
  logic [14:0]   instr_q;
  logic          read_q;
  logic [DW-1:0] rx_q;
  logic [DW-1:0] tx_q;
  logic          rise;
  logic          fall;
  logic          data_ph;

  assign rise    = sclk_i & ~sclk_q & ~cs_n_i;
  assign fall    = ~sclk_i & sclk_q & ~cs_n_i;
  assign data_ph = (icnt_q == 5'h10);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk_i;
    end
  end

  // instruction phase and address tracking
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      icnt_q  <= 5'h00;
      instr_q <= 15'h0000;
      read_q  <= 1'b0;
      addr_o  <= '0;
    end else if (cs_n_i) begin
      icnt_q <= 5'h00;
    end else if (rise && !data_ph) begin
      instr_q <= {instr_q[13:0], sdi_i};
      icnt_q  <= icnt_q + 5'h01;
      if (icnt_q == srxpc_pkg::INSTR_LAST) begin
        read_q <= instr_q[14];
        addr_o <= AW'({instr_q[13:0], sdi_i});
      end
    end else if (rise && dcnt_q == 3'h7) begin
      addr_o <= addr_o + AW'(1);
    end
  end

  // data receive and write strobe
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dcnt_q    <= 3'h0;
      rx_q      <= '0;
      wr_stb_o  <= 1'b0;
      wr_addr_o <= '0;
      wr_data_o <= '0;
    end else begin
      wr_stb_o <= 1'b0;
      if (cs_n_i) begin
        dcnt_q <= 3'h0;
      end else if (rise && data_ph) begin
        rx_q   <= {rx_q[DW-2:0], sdi_i};
        dcnt_q <= dcnt_q + 3'h1;
        if (dcnt_q == 3'h7 && !read_q) begin
          wr_stb_o  <= 1'b1;
          wr_addr_o <= addr_o;
          wr_data_o <= {rx_q[DW-2:0], sdi_i};
        end
      end
    end
  end

  // read data leaves on falling edges, first bit after the last address bit
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_q       <= '0;
      sdo_o      <= 1'b0;
      sdo_oe_n_o <= 1'b1;
    end else begin
      sdo_oe_n_o <= ~(~cs_n_i & data_ph & read_q);
      if (fall && data_ph && read_q) begin
        if (dcnt_q == 3'h0) begin
          sdo_o <= rd_data_i[DW-1];
          tx_q  <= {rd_data_i[DW-2:0], 1'b0};
        end else begin
          sdo_o <= tx_q[DW-1];
          tx_q  <= {tx_q[DW-2:0], 1'b0};
        end
      end
    end
  end

endmodule : srxpc_serial_port

// file: srxpc_regs.sv
/*
  srxpc_regs: control register bank for the eight-lane serial receive PHY.
  Holds power-down, recovery reset, recovery mode and lane 0/1 equalizer
  settings and drives them as static controls to the PHY analog.
  Assumes the serial control port pins are synchronous to core_clk_i.
*/
`timescale 1ns/10ps
module srxpc_regs #(
  parameter int unsigned LANES = srxpc_pkg::LANES
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             spi_cs_n_i,
  input  wire logic             spi_sclk_i,
  input  wire logic             spi_sdi_i,
  output logic                  spi_sdo_o,
  output logic                  spi_sdo_oe_n_o,
  output logic [LANES-1:0]      lane_phy_power_down_o,
  output logic                  bias_power_down_o,
  output logic                  sync_buffer_power_down_o,
  output logic                  recovery_logic_reset_n_o,
  output logic                  half_rate_enable_o,
  output logic [2:0]            oversample_sel_o,
  output logic [3:0]            lane0_equalizer_code_o,
  output logic [3:0]            lane1_equalizer_code_o,
  output logic [1:0]            lane_eq_manual_o
);

  localparam int unsigned AW = srxpc_pkg::ADDR_W;
  localparam int unsigned DW = srxpc_pkg::DATA_W;

  logic [1:0]    rst_sync_q;
  logic          rst_n;
  logic [AW-1:0] addr;
  logic          wr_stb;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [DW-1:0] rd_data;

  logic          receiver_master_power_down_q;
  logic [DW-1:0] lane_phy_power_down_q;
  logic [1:0]    gen_pd_q;
  logic          cdr_run_q;
  logic [DW-1:0] cdr_mode_q;
  logic [DW-1:0] eq01_q;

  function automatic logic eq_is_manual(input logic [3:0] code);
    eq_is_manual = (code == srxpc_pkg::EQ_MANUAL);
  endfunction : eq_is_manual

  // one-hot {by4, by2, none}; reserved code gives all zero
  function automatic logic [2:0] div_decode(input logic [1:0] code);
    unique case (code)
      srxpc_pkg::DIV_NONE: div_decode = 3'h1;
      srxpc_pkg::DIV_BY2:  div_decode = 3'h2;
      srxpc_pkg::DIV_BY4:  div_decode = 3'h4;
      default:             div_decode = 3'h0;
    endcase
  endfunction : div_decode

  // release is delayed two edges so every flop below leaves reset on the same edge
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  srxpc_serial_port #(
    .AW (AW),
    .DW (DW)
  ) u_port (
    .clk_i      (core_clk_i),
    .rst_n_i    (rst_n),
    .cs_n_i     (spi_cs_n_i),
    .sclk_i     (spi_sclk_i),
    .sdi_i      (spi_sdi_i),
    .rd_data_i  (rd_data),
    .sdo_o      (spi_sdo_o),
    .sdo_oe_n_o (spi_sdo_oe_n_o),
    .addr_o     (addr),
    .wr_stb_o   (wr_stb),
    .wr_addr_o  (wr_addr),
    .wr_data_o  (wr_data)
  );

  // register writes; unmapped addresses are ignored
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      receiver_master_power_down_q <= srxpc_pkg::RST_MASTER_PD[srxpc_pkg::MASTER_PD_BIT];
      lane_phy_power_down_q        <= srxpc_pkg::RST_PHY_PD;
      gen_pd_q                     <= srxpc_pkg::RST_GEN_PD[1:0];
      cdr_run_q                    <= srxpc_pkg::RST_CDR_RST[srxpc_pkg::CDR_RUN_BIT];
      cdr_mode_q                   <= srxpc_pkg::RST_CDR_MODE;
      eq01_q                       <= srxpc_pkg::RST_EQ_01;
    end else if (wr_stb) begin
      unique case (wr_addr)
        srxpc_pkg::ADDR_MASTER_PD:
          receiver_master_power_down_q <= wr_data[srxpc_pkg::MASTER_PD_BIT];
        srxpc_pkg::ADDR_PHY_PD:   lane_phy_power_down_q <= wr_data;
        srxpc_pkg::ADDR_GEN_PD:   gen_pd_q <= wr_data[1:0];
        srxpc_pkg::ADDR_CDR_RST:  cdr_run_q <= wr_data[srxpc_pkg::CDR_RUN_BIT];
        srxpc_pkg::ADDR_CDR_MODE: cdr_mode_q <= wr_data;
        srxpc_pkg::ADDR_EQ_01:    eq01_q <= wr_data;
        default: ;
      endcase
    end
  end

  // read back; reserved read-only bits and unmapped addresses read zero
  always_comb begin
    rd_data = '0;
    unique case (addr)
      srxpc_pkg::ADDR_MASTER_PD: rd_data[srxpc_pkg::MASTER_PD_BIT] = receiver_master_power_down_q;
      srxpc_pkg::ADDR_PHY_PD:    rd_data = lane_phy_power_down_q;
      srxpc_pkg::ADDR_GEN_PD:    rd_data[1:0] = gen_pd_q;
      srxpc_pkg::ADDR_CDR_RST:   rd_data[srxpc_pkg::CDR_RUN_BIT] = cdr_run_q;
      srxpc_pkg::ADDR_CDR_MODE:  rd_data = cdr_mode_q;
      srxpc_pkg::ADDR_EQ_01:     rd_data = eq01_q;
      default:                   rd_data = '0;
    endcase
  end

  // power controls; the master bit overrides every lane so no lane can be
  // left biased while the shared bias is off
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      lane_phy_power_down_o    <= '1;
      bias_power_down_o        <= 1'b1;
      sync_buffer_power_down_o <= srxpc_pkg::RST_GEN_PD[srxpc_pkg::SYNC_PD_BIT];
    end else begin
      for (int i = 0; i < LANES; i++) begin
        lane_phy_power_down_o[i] <= lane_phy_power_down_q[i]
                                    | receiver_master_power_down_q;
      end
      bias_power_down_o        <= receiver_master_power_down_q;
      sync_buffer_power_down_o <= gen_pd_q[srxpc_pkg::SYNC_PD_BIT];
    end
  end

  // recovery controls; held in reset while the reset bit reads 0
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      recovery_logic_reset_n_o <= srxpc_pkg::RST_CDR_RST[srxpc_pkg::CDR_RUN_BIT];
      half_rate_enable_o       <= srxpc_pkg::RST_CDR_MODE[srxpc_pkg::HALF_RATE_BIT];
      oversample_sel_o         <= 3'h1;
    end else begin
      recovery_logic_reset_n_o <= cdr_run_q;
      half_rate_enable_o       <= cdr_mode_q[srxpc_pkg::HALF_RATE_BIT];
      oversample_sel_o <= div_decode(
        cdr_mode_q[srxpc_pkg::DIV_LSB +: srxpc_pkg::DIV_W]);
    end
  end

  // equalizer codes; a zero code hands the lane over to manual settings
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      lane0_equalizer_code_o <= srxpc_pkg::RST_EQ_01[3:0];
      lane1_equalizer_code_o <= srxpc_pkg::RST_EQ_01[7:4];
      lane_eq_manual_o       <= 2'h0;
    end else begin
      lane0_equalizer_code_o <= eq01_q[srxpc_pkg::EQ0_LSB +: srxpc_pkg::EQ_W];
      lane1_equalizer_code_o <= eq01_q[srxpc_pkg::EQ1_LSB +: srxpc_pkg::EQ_W];
      lane_eq_manual_o[0] <= eq_is_manual(eq01_q[srxpc_pkg::EQ0_LSB +: srxpc_pkg::EQ_W]);
      lane_eq_manual_o[1] <= eq_is_manual(eq01_q[srxpc_pkg::EQ1_LSB +: srxpc_pkg::EQ_W]);
    end
  end

  // write-to-output latency is two edges after the strobe: register, then output flop
  property p_lane_hi_pd;
    @(posedge core_clk_i) disable iff (!rst_n)
    wr_stb && wr_addr == srxpc_pkg::ADDR_PHY_PD && wr_data[7]
      |-> ##2 lane_phy_power_down_o[7];
  endproperty
  a_lane_hi_pd: assert property (p_lane_hi_pd) else $error("lane 7 not powered down");

  property p_lane_lo_pd;
    @(posedge core_clk_i) disable iff (!rst_n)
    wr_stb && wr_addr == srxpc_pkg::ADDR_PHY_PD && !wr_data[0]
      && !receiver_master_power_down_q ##1 !wr_stb[*1]
      |-> ##1 !lane_phy_power_down_o[0];
  endproperty
  a_lane_lo_pd: assert property (p_lane_lo_pd) else $error("lane 0 wrongly powered down");

  property p_sync_pd;
    @(posedge core_clk_i) disable iff (!rst_n)
    wr_stb && wr_addr == srxpc_pkg::ADDR_GEN_PD
      |-> ##2 sync_buffer_power_down_o == $past(wr_data[1], 2);
  endproperty
  a_sync_pd: assert property (p_sync_pd) else $error("sync buffer control mismatch");

  property p_clock_recovery_reset_ctrl;
    @(posedge core_clk_i) disable iff (!rst_n)
    wr_stb && wr_addr == srxpc_pkg::ADDR_CDR_RST
      |-> ##2 recovery_logic_reset_n_o == $past(wr_data[srxpc_pkg::CDR_RUN_BIT], 2);
  endproperty
  a_clock_recovery_reset_ctrl: assert property (p_clock_recovery_reset_ctrl) else $error("recovery reset mismatch");

  property p_half_rate;
    @(posedge core_clk_i) disable iff (!rst_n)
    wr_stb && wr_addr == srxpc_pkg::ADDR_CDR_MODE
      |-> ##2 half_rate_enable_o == $past(wr_data[5], 2);
  endproperty
  a_half_rate: assert property (p_half_rate) else $error("half rate select mismatch");

  property p_div_none;
    @(posedge core_clk_i) disable iff (!rst_n)
    cdr_mode_q[2:1] == 2'h0 |=> oversample_sel_o == 3'h1;
  endproperty
  a_div_none: assert property (p_div_none) else $error("no-division select wrong");

  property p_div_two;
    @(posedge core_clk_i) disable iff (!rst_n)
    cdr_mode_q[2:1] == 2'h1 |=> oversample_sel_o == 3'h2;
  endproperty
  a_div_two: assert property (p_div_two) else $error("divide by 2 select wrong");

  property p_div_four;
    @(posedge core_clk_i) disable iff (!rst_n)
    cdr_mode_q[2:1] == 2'h2 |=> oversample_sel_o == 3'h4;
  endproperty
  a_div_four: assert property (p_div_four) else $error("divide by 4 select wrong");

  property p_eq_codes;
    @(posedge core_clk_i) disable iff (!rst_n)
    wr_stb && wr_addr == srxpc_pkg::ADDR_EQ_01
      |-> ##2 {lane1_equalizer_code_o, lane0_equalizer_code_o} == $past(wr_data, 2)
          && lane_eq_manual_o[0] == ($past(wr_data[3:0], 2) == 4'h0);
  endproperty
  a_eq_codes: assert property (p_eq_codes) else $error("equalizer code mismatch");

  property p_master_pd;
    @(posedge core_clk_i) disable iff (!rst_n)
    receiver_master_power_down_q[*2] |-> bias_power_down_o && (&lane_phy_power_down_o);
  endproperty
  a_master_pd: assert property (p_master_pd) else $error("master power-down not applied");

  // master released for two cycles must hand the bias back
  property p_master_off;
    @(posedge core_clk_i) disable iff (!rst_n)
    (!receiver_master_power_down_q)[*2] |-> !bias_power_down_o;
  endproperty
  a_master_off: assert property (p_master_off) else $error("bias still powered down");

  property p_bias_pd;
    @(posedge core_clk_i) disable iff (!rst_n)
    wr_stb && wr_addr == srxpc_pkg::ADDR_MASTER_PD
      |-> ##2 bias_power_down_o == $past(wr_data[0], 2);
  endproperty
  a_bias_pd: assert property (p_bias_pd) else $error("bias control mismatch");

  // only with the master bit clear, since that bit masks every lane
  property p_lane_mid_pd;
    @(posedge core_clk_i) disable iff (!rst_n)
    wr_stb && wr_addr == srxpc_pkg::ADDR_PHY_PD && !receiver_master_power_down_q
      ##1 (!wr_stb)[*1]
      |-> ##1 lane_phy_power_down_o[7:2] == $past(wr_data[7:2], 2);
  endproperty
  a_lane_mid_pd: assert property (p_lane_mid_pd) else $error("lanes 2 to 7 mismatch");

  property p_lane_one_pd;
    @(posedge core_clk_i) disable iff (!rst_n)
    wr_stb && wr_addr == srxpc_pkg::ADDR_PHY_PD && wr_data[1]
      |-> ##2 lane_phy_power_down_o[1];
  endproperty
  a_lane_one_pd: assert property (p_lane_one_pd) else $error("lane 1 not powered down");

  property p_eq_manual_hi;
    @(posedge core_clk_i) disable iff (!rst_n)
    wr_stb && wr_addr == srxpc_pkg::ADDR_EQ_01
      |-> ##2 lane_eq_manual_o[1] == ($past(wr_data[7:4], 2) == 4'h0);
  endproperty
  a_eq_manual_hi: assert property (p_eq_manual_hi) else $error("lane 1 manual mismatch");

  // sdo must be released whenever the port is deselected
  property p_sdo_quiet;
    @(posedge core_clk_i) disable iff (!rst_n)
    spi_cs_n_i |=> spi_sdo_oe_n_o;
  endproperty
  a_sdo_quiet: assert property (p_sdo_quiet) else $error("sdo driven while deselected");

  // static controls: the PHY analog must not see a glitch between writes
  property p_controls_stand;
    @(posedge core_clk_i) disable iff (!rst_n)
    !wr_stb |-> ##2 $stable({lane_phy_power_down_o, bias_power_down_o,
                             sync_buffer_power_down_o, recovery_logic_reset_n_o,
                             half_rate_enable_o, oversample_sel_o,
                             lane0_equalizer_code_o, lane1_equalizer_code_o,
                             lane_eq_manual_o});
  endproperty
  a_controls_stand: assert property (p_controls_stand) else $error("output moved unwritten");

endmodule : srxpc_regs

// file: srxpc_regs_tb.sv
/*
  srxpc_regs_tb: self-checking bench for the receive PHY control register
  bank, driving the serial control port directly from the bench.
  Assumes srxpc_pkg is compiled first; all inputs change at the falling edge.
*/
`timescale 1ns/10ps
module srxpc_regs_tb;
  logic       core_clk_i = 1'b0;
  logic       rst_n_i    = 1'b0;
  logic       spi_cs_n_i = 1'b1;
  logic       spi_sclk_i = 1'b0;
  logic       spi_sdi_i  = 1'b0;
  logic       spi_sdo_o;
  logic       spi_sdo_oe_n_o;
  logic [7:0] lane_pd;
  logic       bias_pd;
  logic       sync_pd;
  logic       cdr_rst_n;
  logic       half_rate;
  logic [2:0] ovs_sel;
  logic [3:0] eq0;
  logic [3:0] eq1;
  logic [1:0] eq_manual;
  logic       oe_seen;
  logic [7:0] rx;
  int         fail_count  = 0;
  int         comparisons = 0;

  srxpc_regs dut (
    .core_clk_i               (core_clk_i),
    .rst_n_i                  (rst_n_i),
    .spi_cs_n_i               (spi_cs_n_i),
    .spi_sclk_i               (spi_sclk_i),
    .spi_sdi_i                (spi_sdi_i),
    .spi_sdo_o                (spi_sdo_o),
    .spi_sdo_oe_n_o           (spi_sdo_oe_n_o),
    .lane_phy_power_down_o    (lane_pd),
    .bias_power_down_o        (bias_pd),
    .sync_buffer_power_down_o (sync_pd),
    .recovery_logic_reset_n_o (cdr_rst_n),
    .half_rate_enable_o       (half_rate),
    .oversample_sel_o         (ovs_sel),
    .lane0_equalizer_code_o   (eq0),
    .lane1_equalizer_code_o   (eq1),
    .lane_eq_manual_o         (eq_manual)
  );

  always #2.5 core_clk_i = ~core_clk_i;

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : tick

  // three core cycles per sclk phase keeps the port's four-cycle minimum with margin
  task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rd_byte);
    for (int i = 7; i >= 0; i--) begin
      spi_sdi_i  = tx[i];
      spi_sclk_i = 1'b0;
      tick(3);
      rd_byte[i] = spi_sdo_o;
      oe_seen    = spi_sdo_oe_n_o;
      spi_sclk_i = 1'b1;
      tick(3);
    end
  endtask : spi_byte

  task automatic spi_begin(input logic rd, input logic [14:0] addr);
    spi_sclk_i = 1'b0;
    spi_cs_n_i = 1'b0;
    tick(2);
    spi_byte({rd, addr[14:8]}, rx);
    spi_byte(addr[7:0], rx);
  endtask : spi_begin

  task automatic spi_end();
    spi_cs_n_i = 1'b1;
    spi_sclk_i = 1'b0;
    tick(6);
  endtask : spi_end

  task automatic wr(input logic [14:0] addr, input logic [7:0] data);
    spi_begin(1'b0, addr);
    spi_byte(data, rx);
    spi_end();
  endtask : wr

  task automatic rd_chk(input logic [14:0] addr, input logic [7:0] exp);
    spi_begin(1'b1, addr);
    spi_byte(8'h00, rx);
    spi_end();
    check(oe_seen, 1'b0, "sdo enable");
    check(rx, exp, "read data");
  endtask : rd_chk

  task automatic test_reset_state();
    check(lane_pd, 8'hFF, "lane pd");
    check(bias_pd, 1'b1, "bias pd");
    check(sync_pd, 1'b0, "sync pd");
    check(cdr_rst_n, 1'b1, "cdr run");
    check(half_rate, 1'b1, "half rate");
    check(ovs_sel, 3'h1, "oversample");
    check({eq1, eq0, eq_manual}, 10'h220, "eq codes");
  endtask : test_reset_state

  task automatic test_reg_resets();
    rd_chk(srxpc_pkg::ADDR_MASTER_PD, 8'h01);
    rd_chk(srxpc_pkg::ADDR_PHY_PD, 8'h00);
    rd_chk(srxpc_pkg::ADDR_GEN_PD, 8'h00);
    rd_chk(srxpc_pkg::ADDR_CDR_RST, 8'h01);
    rd_chk(srxpc_pkg::ADDR_CDR_MODE, 8'h20);
    rd_chk(srxpc_pkg::ADDR_EQ_01, 8'h88);
  endtask : test_reg_resets

  task automatic test_lane_power();
    wr(srxpc_pkg::ADDR_MASTER_PD, 8'hFE);
    check({lane_pd, bias_pd}, 9'h000, "master off");
    for (int i = 0; i < 8; i++) begin
      wr(srxpc_pkg::ADDR_PHY_PD, 8'h01 << i);
      check(lane_pd, 8'h01 << i, "lane select");
    end
    wr(srxpc_pkg::ADDR_PHY_PD, 8'h0C);
    wr(srxpc_pkg::ADDR_MASTER_PD, 8'h01);
    check({lane_pd, bias_pd}, 9'h1FF, "master on");
    rd_chk(srxpc_pkg::ADDR_MASTER_PD, 8'h01);
    rd_chk(srxpc_pkg::ADDR_PHY_PD, 8'h0C);
    wr(srxpc_pkg::ADDR_MASTER_PD, 8'h00);
    check(lane_pd, 8'h0C, "lanes 2 and 3");
  endtask : test_lane_power

  task automatic test_sync_and_cdr();
    wr(srxpc_pkg::ADDR_GEN_PD, 8'hFF);
    check(sync_pd, 1'b1, "sync pd set");
    rd_chk(srxpc_pkg::ADDR_GEN_PD, 8'h03);
    wr(srxpc_pkg::ADDR_GEN_PD, 8'h01);
    check(sync_pd, 1'b0, "sync pd clear");
    wr(srxpc_pkg::ADDR_CDR_RST, 8'hFE);
    check(cdr_rst_n, 1'b0, "cdr held");
    rd_chk(srxpc_pkg::ADDR_CDR_RST, 8'h00);
    wr(srxpc_pkg::ADDR_CDR_RST, 8'hFF);
    check(cdr_rst_n, 1'b1, "cdr run");
    rd_chk(srxpc_pkg::ADDR_CDR_RST, 8'h01);
  endtask : test_sync_and_cdr

  task automatic test_cdr_mode();
    logic [2:0] exp_sel [3] = '{3'h1, 3'h2, 3'h4};
    logic [7:0] val;
    for (int d = 0; d < 3; d++) begin
      val = {2'(d), 1'(d[0]), 2'h3, 2'(d), 1'(d[1])};
      wr(srxpc_pkg::ADDR_CDR_MODE, val);
      check(ovs_sel, exp_sel[d], "division");
      check(half_rate, val[5], "half rate");
      rd_chk(srxpc_pkg::ADDR_CDR_MODE, val);
    end
  endtask : test_cdr_mode

  task automatic test_equalizer();
    for (int n = 0; n < 16; n++) begin
      wr(srxpc_pkg::ADDR_EQ_01, {4'(15 - n), 4'(n)});
      check({eq1, eq0}, {4'(15 - n), 4'(n)}, "eq codes");
      check(eq_manual, {n == 15, n == 0}, "eq manual");
    end
    rd_chk(srxpc_pkg::ADDR_EQ_01, 8'h0F);
  endtask : test_equalizer

  // unmapped writes, streaming into the next address and an aborted frame
  task automatic test_refusals();
    wr(15'h0202, 8'hAA);
    rd_chk(15'h0202, 8'h00);
    rd_chk(srxpc_pkg::ADDR_PHY_PD, 8'h0C);
    spi_begin(1'b0, 15'h0205);
    spi_byte(8'hFF, rx);
    spi_byte(8'h00, rx);
    spi_end();
    check(cdr_rst_n, 1'b0, "streamed write");
    spi_begin(1'b0, srxpc_pkg::ADDR_EQ_01);
    spi_byte(8'h55, rx);
    spi_byte(8'h00, rx);
    spi_byte(8'h00, rx);
    spi_end();
    spi_begin(1'b0, srxpc_pkg::ADDR_EQ_01);
    for (int i = 0; i < 7; i++) begin
      spi_sdi_i  = 1'b0;
      spi_sclk_i = 1'b0;
      tick(3);
      spi_sclk_i = 1'b1;
      tick(3);
    end
    spi_sdi_i = 1'b1;
    spi_end();
    check({eq1, eq0}, 8'h55, "aborted byte");
    spi_begin(1'b1, srxpc_pkg::ADDR_MASTER_PD);
    spi_byte(8'h00, rx);
    check(rx, 8'h00, "stream read");
    spi_byte(8'h00, rx);
    spi_end();
    check(rx, 8'h0C, "stream next address");
  endtask : test_refusals

  initial begin
    tick(20);
    test_reset_state();
    rst_n_i = 1'b1;
    tick(4);
    test_reset_state();
    test_reg_resets();
    test_lane_power();
    test_sync_and_cdr();
    test_cdr_mode();
    test_equalizer();
    test_refusals();
    stop_test();
  end

  // the full sequence needs about 10000 core cycles; allow five times that
  initial begin
    #250000;
    fail_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule : srxpc_regs_tb
